// *** core/adc_serial_consts.svh ***
/*
 Offsets, field positions, reset values and timing counts of the ADC serial control block.
 Assumes a 200 MHz pclk; included by every core file that needs a number.
*/
`ifndef ADC_SERIAL_CONSTS_SVH
`define ADC_SERIAL_CONSTS_SVH

`define CLK_PERIOD_NS 5
`define INT_STEP_NS 400
`define INT_STEP_CYC ((`INT_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_CONFIG_OFS 12'h000
`define REG_STATUS_OFS 12'h004
`define REG_COUNT_OFS 12'h008

`define PIN_SCLK 0
`define PIN_CS 1
`define PIN_DIN 2
`define PIN_COMP 3
`define PIN_PWR_N 4
`define PIN_PWR_FLT 5
`define SYNC_RESET 6'h12

`define RESULT_BITS 12
`define SAR_MSB_TRIAL 12'h800
`define SAR_LAST_IDX 4'hB
`define CTRL_SEL_LSB 4
`define CTRL_POL_BIT 3
`define CTRL_CFG_BIT 2
`define CTRL_MODE_LSB 0
`define TRACK_BIT_NUM 4'h5
`define HOLD_BIT_NUM 4'h8

`define STAT_CTRL_LSB 12
`define STAT_BUSY_BIT 20
`define STAT_PD_BIT 21

`endif

// *** core/adc_serial_pkg.sv ***
/*
 Types of the ADC serial control block: states, modes and the state records.
 Assumes the constants header is compiled alongside.
*/
package adc_serial_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CTRL = 3'h1,
		ST_STROBE = 3'h3,
		ST_CONV = 3'h2,
		ST_OUT = 3'h6
	} state_e;

	typedef enum logic [1:0] {
		MODE_PD_FULL = 2'h0,
		MODE_PD_FAST = 2'h1,
		MODE_INT = 2'h2,
		MODE_EXT = 2'h3
	} mode_e;

	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
		logic [5:0] s3;
		logic [5:0] lvl;
		logic [5:0] rise;
		logic [5:0] fall;
	} sync_s;

	typedef struct packed {
		logic [11:0] code;
		logic [3:0] idx;
		logic busy;
		logic done;
		logic [11:0] result;
	} sar_s;

	typedef struct packed {
		state_e st;
		logic [3:0] bit_cnt;
		logic [5:0] ctl_sh;
		logic [7:0] ctl_byte;
		mode_e mode;
		logic single;
		logic unipolar;
		logic [3:0] pos_sel;
		logic [3:0] neg_sel;
		logic neg_common;
		logic track;
		logic hold_neg;
		logic strobe;
		logic strobe_oe_n;
		logic dout;
		logic dout_oe_n;
		logic [11:0] out_sh;
		logic [3:0] out_cnt;
		logic [15:0] div_cnt;
		logic sar_start;
		logic sar_step;
		logic pd_soft;
		logic pd_fast;
		logic powered_down;
		logic ref_int;
		logic [15:0] cfg_div;
		logic [15:0] conv_cnt;
		logic [11:0] last_res;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} top_s;

endpackage

// *** core/adc_link_if.sv ***
/*
 Carrier between the control core, the pin synchroniser and the approximation engine.
 Assumes all three sit on pclk.
*/
interface adc_link_if;
	logic [5:0] lvl;
	logic [5:0] rise;
	logic [5:0] fall;
	logic start;
	logic step;
	logic done;
	logic busy;
	logic [11:0] code;
	logic [11:0] result;

	modport sync_mp(output lvl, rise, fall);
	modport sar_mp(input lvl, start, step, output code, done, busy, result);
endinterface

// *** core/pin_sync.sv ***
/*
 Three-stage synchroniser with edge flags for the serial pins and the comparator.
 Assumes asynchronous pins; a level counts once stages two and three agree.
*/
`include "adc_serial_consts.svh"
module pin_sync
	import adc_serial_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [5:0] raw,
	adc_link_if.sync_mp lk
);
	sync_s r;
	sync_s n;
	logic [5:0] agree;

	always_comb begin
		n = r;
		n.s1 = raw;
		n.s2 = r.s1;
		n.s3 = r.s2;
		agree = ~(r.s2 ^ r.s3);
		n.lvl = (r.lvl & ~agree) | (r.s2 & agree);
		n.rise = n.lvl & ~r.lvl;
		n.fall = r.lvl & ~n.lvl;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.s1 <= `SYNC_RESET;
			r.s2 <= `SYNC_RESET;
			r.s3 <= `SYNC_RESET;
			r.lvl <= `SYNC_RESET;
		end else begin
			r <= n;
		end
	end

	assign lk.lvl = r.lvl;
	assign lk.rise = r.rise;
	assign lk.fall = r.fall;

	// per pin: another pin may be mid-transition while this one settles
	AST_SYNC_AGREE: assert property (@(posedge pclk) disable iff (!presetn) // see RQ1
		((r.lvl ^ $past(r.lvl)) & (($past(r.s2) ^ $past(r.s3)) | (r.lvl ^ $past(r.s2)))) == 6'h00)
		else $error("level changed without stage agreement");
endmodule

// *** core/sar_engine.sv ***
/*
 Successive-approximation register: one bit decision per step, most significant first.
 Assumes the comparator level arrives synchronised and settles before each step.
*/
`include "adc_serial_consts.svh"
module sar_engine
	import adc_serial_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	adc_link_if.sar_mp lk
);
	sar_s r;
	sar_s n;
	logic [3:0] step_cnt;

	always_comb begin
		n = r;
		n.done = 1'b0;
		if (lk.start) begin
			n.code = `SAR_MSB_TRIAL;
			n.idx = `SAR_LAST_IDX;
			n.busy = 1'b1;
		end else if (lk.step && r.busy) begin // see RQ10
			if (!lk.lvl[`PIN_COMP])
				n.code[r.idx] = 1'b0;
			if (r.idx == 4'h0) begin
				n.busy = 1'b0;
				n.done = 1'b1;
				n.result = n.code;
			end else begin
				n.idx = 4'(r.idx - 4'h1);
				n.code[n.idx] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			step_cnt <= 4'h0;
		end else begin
			r <= n;
			if (lk.start)
				step_cnt <= 4'h0;
			else if (lk.step && r.busy)
				step_cnt <= 4'(step_cnt + 4'h1);
		end
	end

	assign lk.code = r.code;
	assign lk.done = r.done;
	assign lk.busy = r.busy;
	assign lk.result = r.result;

	AST_SAR_START: assert property (@(posedge pclk) disable iff (!presetn) // see RQ10
		lk.start |=> r.code == 12'h800 && r.busy)
		else $error("conversion did not begin at mid scale");
	AST_SAR_TWELVE: assert property (@(posedge pclk) disable iff (!presetn) // see RQ10
		r.done |-> step_cnt == 4'hC)
		else $error("result not after twelve decisions");
endmodule

// *** core/adc_serial_ctrl.sv ***
/*
 Serial interface and conversion sequencing of a four-input 12-bit converter, with an APB
 window for software. Assumes serial pins and comparator are asynchronous to pclk (200 MHz)
 and that the serial clock is at least a few pclk periods per phase.
*/
// Implementation choices: the APB interface to the registers and the register addresses.
// Operation
// RQ1: input bits taken on serial clock rise
// RQ2: output bits change on serial clock fall
// RQ3: data output floats while select high
// RQ4: no input bits taken while select high
// RQ5: internal mode: strobe low while converting
// RQ6: external mode: strobe high one period before MSB
// RQ7: external mode: strobe floats while select high
// RQ8: external mode: serial clock paces decisions
// RQ9: shutdown low powers down; high/float set compensation
// RQ10: twelve-bit result by successive approximation
// RQ11: single-ended: selected input against common return
// RQ12: differential: fixed pairs of inputs
// RQ13: acquisition three clocks, closes after eighth bit
// RQ14: hold then switch capacitor to negative node
// RQ15: differential samples positive node only
// RQ16: leading zeros skipped; first one starts byte
// RQ17: byte: start, channel, polarity, config, mode
// RQ18: mode bits: two power-down, internal, external
// RQ19: track after fifth bit, hold after eighth
// RQ20: result shifted out MSB first on falls
// RQ21: fields latched at eighth bit, used
`include "adc_serial_consts.svh"
module adc_serial_ctrl
	import adc_serial_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic comp_in,
	input wire logic power_off_input_n,
	input wire logic power_off_input_float,
	output logic dout,
	output logic dout_oe_n,
	output logic conversion_strobe,
	output logic conversion_strobe_oe_n,
	output logic track_en,
	output logic hold_to_neg,
	output logic [3:0] pos_sel,
	output logic [3:0] neg_sel,
	output logic neg_common,
	output logic polarity_unipolar,
	output logic [11:0] dac_code,
	output logic powered_down,
	output logic fast_power_down,
	output logic ref_comp_internal
);
	top_s r;
	top_s n;
	logic cs_hi;
	logic s_rise;
	logic s_fall;
	logic din_lvl;
	logic comp_lvl;
	logic [7:0] byte_in;
	logic [8:0] rt;
	logic acc;

	adc_link_if lk();

	pin_sync i_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.raw({power_off_input_float, power_off_input_n, comp_in, din, cs_n, sclk}),
		.lk(lk.sync_mp)
	);

	sar_engine i_sar_engine (
		.pclk(pclk),
		.presetn(presetn),
		.lk(lk.sar_mp)
	);

	assign cs_hi = lk.lvl[`PIN_CS];
	assign s_rise = lk.rise[`PIN_SCLK];
	assign s_fall = lk.fall[`PIN_SCLK];
	assign din_lvl = lk.lvl[`PIN_DIN];
	assign comp_lvl = lk.lvl[`PIN_COMP];
	assign lk.start = r.sar_start;
	assign lk.step = r.sar_step;

	// {common, neg[3:0], pos[3:0]}; unused select codes connect nothing
	function automatic logic [8:0] route(input logic [2:0] sel, input logic single);
		logic [8:0] v;
		v = 9'h000;
		case (sel)
			3'h1: v = single ? 9'h101 : 9'h021;
			3'h5: v = single ? 9'h102 : 9'h012;
			3'h2: v = single ? 9'h104 : 9'h084;
			3'h6: v = single ? 9'h108 : 9'h048;
			default: v = 9'h000;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// serial sequencing

	always_comb begin
		n = r;
		n.sar_start = 1'b0;
		n.sar_step = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		byte_in = {1'b1, r.ctl_sh, din_lvl};
		rt = route(byte_in[`CTRL_SEL_LSB +: 3], byte_in[`CTRL_CFG_BIT]);
		acc = psel && penable && !r.pready;
		n.dout_oe_n = cs_hi; // see RQ3
		n.strobe_oe_n = cs_hi && r.mode != MODE_INT; // see RQ7
		n.powered_down = !lk.lvl[`PIN_PWR_N] || r.pd_soft; // see RQ9
		n.ref_int = lk.lvl[`PIN_PWR_N] && !lk.lvl[`PIN_PWR_FLT]; // see RQ9
		n.pd_fast = r.pd_soft && r.mode == MODE_PD_FAST;
		case (r.st)
			ST_IDLE: begin
				// zeros before the start bit are dropped
				if (!cs_hi && s_rise && din_lvl && lk.lvl[`PIN_PWR_N]) begin // see RQ16 RQ1 RQ4
					n.st = ST_CTRL;
					n.bit_cnt = 4'h1;
					n.pd_soft = 1'b0;
				end
				if (s_fall)
					n.dout = 1'b0;
			end
			ST_CTRL: begin
				if (s_rise) begin // see RQ1
					n.ctl_sh = {r.ctl_sh[4:0], din_lvl};
					n.bit_cnt = 4'(r.bit_cnt + 4'h1);
					if (r.bit_cnt == 4'h7) begin // see RQ21 RQ17
						n.ctl_byte = byte_in;
						n.mode = mode_e'(byte_in[`CTRL_MODE_LSB +: 2]);
						n.single = byte_in[`CTRL_CFG_BIT];
						n.unipolar = byte_in[`CTRL_POL_BIT];
						n.pos_sel = rt[3:0]; // see RQ11 RQ12
						n.neg_sel = rt[7:4]; // see RQ12
						n.neg_common = rt[8]; // see RQ11
					end
				end
				if (s_fall) begin
					n.dout = 1'b0;
					if (r.bit_cnt == `TRACK_BIT_NUM)
						n.track = 1'b1; // see RQ19 RQ13
					if (r.bit_cnt == `HOLD_BIT_NUM) begin
						// hold opens, capacitor moves to the negative node
						n.track = 1'b0; // see RQ13 RQ14 RQ19
						n.hold_neg = 1'b1; // see RQ14 RQ15
						n.sar_start = 1'b1;
						if (r.mode == MODE_INT) begin
							n.strobe = 1'b0; // see RQ5
							n.div_cnt = 16'h0000;
							n.st = ST_CONV;
						end else begin
							n.strobe = 1'b1; // see RQ6
							n.st = ST_STROBE;
						end
					end
				end
			end
			ST_STROBE: begin
				if (s_fall) begin
					n.strobe = 1'b0; // see RQ6
					n.sar_step = 1'b1; // see RQ8
					n.dout = comp_lvl; // see RQ2 RQ20
					n.st = ST_CONV;
				end
			end
			ST_CONV: begin
				if (r.mode == MODE_INT) begin
					// zero in the divider register means one step per pclk
					if (32'(r.div_cnt) + 32'h1 >= 32'(r.cfg_div)) begin
						n.sar_step = 1'b1;
						n.div_cnt = 16'h0000;
					end else begin
						n.div_cnt = 16'(r.div_cnt + 16'h1);
					end
				end else if (s_fall && lk.busy) begin
					n.sar_step = 1'b1; // see RQ8
					n.dout = comp_lvl; // see RQ2 RQ20
				end
				if (lk.done) begin
					n.hold_neg = 1'b0;
					n.last_res = lk.result;
					n.conv_cnt = 16'(r.conv_cnt + 16'h1);
					if (r.mode == MODE_INT) begin
						n.strobe = 1'b1; // see RQ5
						n.out_sh = lk.result;
						n.out_cnt = 4'hC;
						n.st = ST_OUT;
					end else begin
						n.pd_soft = r.mode == MODE_PD_FULL || r.mode == MODE_PD_FAST; // see RQ18
						n.st = ST_IDLE;
					end
				end
			end
			ST_OUT: begin
				if (s_fall) begin
					n.dout = r.out_sh[11]; // see RQ2 RQ20
					n.out_sh = {r.out_sh[10:0], 1'b0};
					n.out_cnt = 4'(r.out_cnt - 4'h1);
					if (r.out_cnt == 4'h1)
						n.st = ST_IDLE;
				end
			end
			default: n.st = ST_IDLE;
		endcase
		// deselect ends any serial phase; an internal conversion runs on regardless
		if (cs_hi && r.st != ST_IDLE && !(r.st == ST_CONV && r.mode == MODE_INT)) begin // see RQ4
			n.st = ST_IDLE;
			n.track = 1'b0;
			n.hold_neg = 1'b0;
			if (r.mode != MODE_INT)
				n.strobe = 1'b0;
		end
		////////////////////////////////////////////////////////////////////////////
		// apb slave, one wait state
		if (acc) begin
			n.pready = 1'b1;
			case (paddr)
				`REG_CONFIG_OFS: n.prdata = {16'h0000, r.cfg_div};
				`REG_STATUS_OFS: begin
					n.prdata = 32'h00000000;
					n.prdata[11:0] = r.last_res;
					n.prdata[`STAT_CTRL_LSB +: 8] = r.ctl_byte;
					n.prdata[`STAT_BUSY_BIT] = r.st != ST_IDLE;
					n.prdata[`STAT_PD_BIT] = r.powered_down;
				end
				`REG_COUNT_OFS: n.prdata = {16'h0000, r.conv_cnt};
				default: begin
					n.prdata = 32'h00000000;
					n.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && r.pready && pwrite && paddr == `REG_CONFIG_OFS)
			n.cfg_div = pwdata[15:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.dout_oe_n <= 1'b1;
			r.strobe_oe_n <= 1'b1;
			r.mode <= MODE_EXT;
			r.cfg_div <= 16'(`INT_STEP_CYC);
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign dout = r.dout;
	assign dout_oe_n = r.dout_oe_n;
	assign conversion_strobe = r.strobe;
	assign conversion_strobe_oe_n = r.strobe_oe_n;
	assign track_en = r.track;
	assign hold_to_neg = r.hold_neg;
	assign pos_sel = r.pos_sel;
	assign neg_sel = r.neg_sel;
	assign neg_common = r.neg_common;
	assign polarity_unipolar = r.unipolar;
	assign dac_code = lk.code;
	assign powered_down = r.powered_down;
	assign fast_power_down = r.pd_fast;
	assign ref_comp_internal = r.ref_int;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_hold_edge;
		r.st == ST_CTRL && s_fall && !cs_hi && r.bit_cnt == 4'h8;
	endsequence

	sequence seq_msb_edge;
		r.st == ST_STROBE && s_fall && !cs_hi;
	endsequence

	AST_DOUT_FLOAT: assert property (cs_hi |=> r.dout_oe_n) // see RQ3
		else $error("data output driven while deselected");
	AST_IGNORE_DIN: assert property (cs_hi && r.st == ST_IDLE |=> r.st == ST_IDLE) // see RQ4
		else $error("input accepted while deselected");
	AST_INT_STROBE: assert property (seq_hold_edge ##0 r.mode == MODE_INT |=> !r.strobe && r.st == ST_CONV) // see RQ5
		else $error("strobe not low at internal conversion start");
	AST_EXT_STROBE: assert property (seq_hold_edge ##0 r.mode != MODE_INT |=> r.strobe ##0 r.st == ST_STROBE) // see RQ6
		else $error("strobe not raised before the first decision");
	AST_EXT_STROBE_END: assert property (seq_msb_edge |=> !r.strobe && r.sar_step) // see RQ6 RQ8
		else $error("strobe not dropped at the first decision");
	AST_STROBE_FLOAT: assert property (cs_hi && r.mode != MODE_INT |=> r.strobe_oe_n) // see RQ7
		else $error("strobe driven while deselected");
	AST_SHUTDOWN: assert property (!lk.lvl[`PIN_PWR_N] |=> r.powered_down && !r.ref_int) // see RQ9
		else $error("shutdown level ignored");
	AST_HOLD_SWITCH: assert property ($fell(r.track) && !$past(cs_hi) |-> r.hold_neg && r.sar_start) // see RQ13 RQ14
		else $error("hold did not follow acquisition");
	AST_SINGLE_ROUTE: assert property (r.hold_neg && r.single && r.pos_sel != 4'h0 |-> r.neg_common) // see RQ11
		else $error("single-ended negative node not common");
	AST_DIFF_ROUTE: assert property (r.hold_neg && !r.single |-> !r.neg_common && (r.pos_sel | r.neg_sel) != 4'hF) // see RQ12 RQ15
		else $error("differential pair routed wrongly");
	AST_OUT_MSB: assert property (r.st == ST_OUT && s_fall && !cs_hi |=> r.dout == $past(r.out_sh[11])) // see RQ20
		else $error("result bit order wrong");
	AST_APB_ANSWER: assert property (psel && penable && !r.pready |=> r.pready ##1 !r.pready)
		else $error("apb answer not one cycle");
endmodule

// *** verif/adc_host_model.sv ***
/*
 Serial host model for the converter's link: select, clock and data in, result collection.
 Assumes the clock idles low between frames (rising-edge capture, falling-edge shift)
 and an 80 ns clock period.
*/
module adc_host_model (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic conversion_strobe
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk = 1'h0;
		cs_n = 1'h1;
		din = 1'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one clock period: data set in the low half, output taken at the rise
	task automatic pulse(input logic b, output logic got);
		begin
			din = b;
			#40;
			sclk = 1'h1;
			got = dout;
			#40;
			sclk = 1'h0;
		end
	endtask

	task automatic frame(input logic [7:0] ctrl, input int lead, input logic internal,
		output logic [11:0] res, output logic hung);
		logic g;
		logic [15:0] sh;
		int n;
		begin
			cs_n = 1'h0;
			#100;
			repeat (lead) pulse(1'h0, g);
			for (int i = 7; i >= 0; i--) pulse(ctrl[i], g);
			n = 0;
			if (internal) begin
				#200;
				while (conversion_strobe !== 1'h1 && n < 4000) begin
					#10;
					n++;
				end
			end
			hung = n >= 4000;
			// result sits at rises 2..13 of these 16 clocks in both modes
			for (int i = 15; i >= 0; i--) begin
				pulse(1'h0, g);
				sh[i] = g;
			end
			res = sh[14:3];
			#40;
			cs_n = 1'h1;
			// released line: no stale level for the device to pick up
			din = ~din;
			#200;
		end
	endtask

	task automatic loose(input int cnt);
		logic g;
		begin
			repeat (cnt) pulse(1'h1, g);
			din = 1'h0;
		end
	endtask
endmodule

// *** verif/test_adc_serial_conversion_control.sv ***
/*
 Self-checking bench of the converter control: APB register access and serial frames.
 Assumes the host model drives the link and an ideal comparator answers the trial code.
*/
`include "adc_serial_consts.svh"
module test_adc_serial_conversion_control
	import adc_serial_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sclk, cs_n, din, comp_in;
	logic power_off_input_n, power_off_input_float, dout, dout_oe_n, conversion_strobe;
	logic conversion_strobe_oe_n, track_en, hold_to_neg, neg_common, polarity_unipolar;
	logic powered_down, fast_power_down, ref_comp_internal, e, hung;
	logic [11:0] paddr, dac_code, target, res;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] pos_sel, neg_sel;
	logic [7:0] ctrl;
	logic [11:0] snap;
	real t_rise, width;
	int err_total, checks_done;
	logic [2:0] sel_tab[4] = '{3'h1, 3'h5, 3'h2, 3'h6};
	logic [3:0] pos_tab[4] = '{4'h1, 4'h2, 4'h4, 4'h8};
	logic [3:0] neg_tab[4] = '{4'h2, 4'h1, 4'h8, 4'h4};
	logic [11:0] tgt[8] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C, 12'h3C3, 12'h001, 12'hFFE};

	// ideal comparator: input at or above the trial code keeps the bit
	assign comp_in = target >= dac_code;

	adc_serial_ctrl i_adc_serial_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .din(din), .comp_in(comp_in),
		.power_off_input_n(power_off_input_n), .power_off_input_float(power_off_input_float),
		.dout(dout), .dout_oe_n(dout_oe_n), .conversion_strobe(conversion_strobe),
		.conversion_strobe_oe_n(conversion_strobe_oe_n), .track_en(track_en),
		.hold_to_neg(hold_to_neg), .pos_sel(pos_sel), .neg_sel(neg_sel), .neg_common(neg_common),
		.polarity_unipolar(polarity_unipolar), .dac_code(dac_code), .powered_down(powered_down),
		.fast_power_down(fast_power_down), .ref_comp_internal(ref_comp_internal));

	// a released pin shows the inverse of its last level, so a sample taken while floating fails
	adc_host_model i_adc_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout ^ dout_oe_n),
		.conversion_strobe(conversion_strobe ^ conversion_strobe_oe_n));

	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end

	// settle one step so the routing outputs of the same edge have landed
	always @(posedge conversion_strobe) begin
		t_rise = $realtime;
		#1 snap = {pos_sel, neg_sel, neg_common, polarity_unipolar, hold_to_neg, track_en};
	end
	always @(negedge conversion_strobe) width = $realtime - t_rise;

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		begin
			$display("checks %0d mismatches %0d", checks_done, err_total);
			if (err_total == 0 && checks_done > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			checks_done++;
			if (got !== exp) begin
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
				err_total++;
			end
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		begin
			@(posedge pclk);
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'h1;
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (pready !== 1'h1 && n < 50);
			if (n >= 50) begin
				err_total++;
				final_report();
			end
			r = prdata;
			e = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
		end
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		begin
			apb(1'h0, a, 32'h0);
			chk(r, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		power_off_input_n = 1'h1;
		power_off_input_float = 1'h0;
		target = 12'h000;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		repeat (8) @(posedge pclk);
		chk(32'(dout_oe_n), 32'h1);
		chk(32'(conversion_strobe_oe_n), 32'h1);
		chk(32'(ref_comp_internal), 32'h1);
		rd_chk(`REG_CONFIG_OFS, 32'h50);
		// comparator reaches the engine four pclk late, so a decision needs at least five
		apb(1'h1, `REG_CONFIG_OFS, 32'h8);
		rd_chk(`REG_CONFIG_OFS, 32'h8);
		rd_chk(12'h00C, 32'h0);
		chk(32'(e), 32'h1);
		// the four routed channel codes, single-ended then differential, external clock
		for (int i = 0; i < 8; i++) begin
			target <= tgt[i];
			ctrl = {1'h1, sel_tab[i % 4], i[0], i < 4, MODE_EXT};
			width = 0.0;
			i_adc_host_model.frame(ctrl, i % 3, 1'h0, res, hung);
			chk(32'(res), 32'(tgt[i]));
			chk(32'(snap[11:2]), 32'({pos_tab[i % 4], i < 4 ? 4'h0 : neg_tab[i % 4], i < 4, i[0]}));
			chk(32'(snap[1:0]), 32'h2);
			chk(32'(width > 70.0 && width < 90.0), 32'h1);
			chk(32'(dout_oe_n), 32'h1);
			rd_chk(`REG_STATUS_OFS, 32'({2'h0, ctrl, tgt[i]}));
		end
		rd_chk(`REG_COUNT_OFS, 32'h8);
		target <= 12'h96A;
		i_adc_host_model.frame({1'h1, 3'h1, 2'h3, MODE_INT}, 1, 1'h1, res, hung);
		chk(32'({hung, res}), 32'h96A);
		// software power-down modes still convert, then power down
		for (int m = 0; m < 2; m++) begin
			i_adc_host_model.frame({1'h1, 3'h6, 2'h2, m[1:0]}, 0, 1'h0, res, hung);
			chk(32'(res), 32'h96A);
			chk(32'({powered_down, fast_power_down}), 32'({1'h1, m[0]}));
		end
		i_adc_host_model.frame({1'h1, 3'h2, 2'h3, MODE_EXT}, 0, 1'h0, res, hung);
		chk(32'(powered_down), 32'h0);
		rd_chk(`REG_COUNT_OFS, 32'hC);
		// clocks and ones with select high must not start anything
		i_adc_host_model.loose(12);
		rd_chk(`REG_STATUS_OFS, 32'({2'h0, 8'hAF, 12'h96A}));
		rd_chk(`REG_COUNT_OFS, 32'hC);
		@(posedge pclk);
		power_off_input_n <= 1'h0;
		i_adc_host_model.frame({1'h1, 3'h1, 2'h3, MODE_EXT}, 0, 1'h0, res, hung);
		chk(32'(powered_down), 32'h1);
		rd_chk(`REG_COUNT_OFS, 32'hC);
		@(posedge pclk);
		power_off_input_n <= 1'h1;
		power_off_input_float <= 1'h1;
		repeat (8) @(posedge pclk);
		chk(32'({powered_down, ref_comp_internal}), 32'h0);
		final_report();
	end
endmodule
